//--- design/ivlr_params.svh
`ifndef IVLR_PARAMS_SVH
`define IVLR_PARAMS_SVH
// Register byte addresses
`define IVLR_A_IFP 8'h5F
`define IVLR_A_ENA 8'h60
`define IVLR_A_ENB 8'h61
`define IVLR_A_PWR 8'h62
`define IVLR_A_RST 8'h63
`define IVLR_A_VEC 8'h64
`define IVLR_A_MODE 8'h65
// Vector tables
`define IVLR_USER_BASE 16'hDFE0
`define IVLR_HW_BASE 16'hFFC0
// Power control bit positions
`define IVLR_PWR_DET 0
`define IVLR_PWR_LVL 1
`define IVLR_PWR_STP 2
`define IVLR_PWR_RSTE 3
`define IVLR_PWR_FLAG 4
`define IVLR_PWR_TRE 5
// Reset status bit positions
`define IVLR_RS_POR 0
`define IVLR_RS_LVD 1
`define IVLR_RS_PRF 2
`define IVLR_RS_WDT 3
`define IVLR_RS_TMP 4
`define IVLR_RS_ILOP 5
`define IVLR_RS_ILAD 6
// Reset values
`define IVLR_RST_STAT_RV 8'h03
`define IVLR_PWR_RV 6'h09
`define IVLR_VEC_RST_USER 16'hDFFE
`define IVLR_VEC_RST_HW 16'hFFFE
// Cycles a non-voltage reset is held
`define IVLR_HOLD_CYC 4'h4
`endif

//--- design/ivlr_pkg.sv
`default_nettype none
package ivlr_pkg;
    // Peripheral status flags, levels owned by each peripheral
    typedef struct packed {
        logic keypin_flag;
        logic press_done_flag;
        logic accel_done_flag;
        logic periodic_tick_flag;
        logic carrier_seen_flag;
        logic byte_decoded_flag;
        logic conversion_done_flag;
        logic serial_rx_full_flag;
        logic serial_fault_flag;
        logic serial_tx_empty_flag;
        logic counter_wrap_flag;
        logic chan_b_flag;
        logic chan_a_flag;
        logic wake_interval_flag;
    } ivlr_src_s;
    // Reset requests other than power-on and undervolt, one-cycle pulses
    typedef struct packed {
        logic periodic_reset_flag;
        logic watchdog_timeout;
        logic temp_restart;
        logic illegal_opcode;
        logic illegal_address;
    } ivlr_rsrc_s;
    // Vector presented to the core
    typedef struct packed {
        logic req;
        logic [3:0] num;
        logic [15:0] user_addr;
        logic [15:0] hw_addr;
    } ivlr_vec_s;
    typedef enum logic [1:0] {MD_RUN, MD_WAIT, MD_STOP4, MD_STOP_DEEP} ivlr_mode_e;
    typedef enum logic [1:0] {RS_RUN, RS_HOLD_LV, RS_HOLD_CNT} ivlr_rs_e;
endpackage
`default_nettype wire

//--- design/ivlr_top.sv
// Summary of operation
// (R1) Two-byte vectors; higher address wins priority
// (R2) Hardware fetch uses table FFC0 to FFFF
// (R3) Interrupt condition sets bit at 005F
// (R4) Request needs flag and local enable
// (R5) Core masks, stacks, fetches highest vector
// (R6) Vector trigger wakes from stop and wait
// (R7) Vectors 15,14,13: keypins, pressure, acceleration
// (R8) Vector 12: periodic tick, own enable
// (R9) Vector 11: two receiver flags, one enable
// (R10) Vector 10: conversion done, own enable
// (R11) Vector 8: serial rx/fault and tx
// (R12) Vectors 7,6,5: timer wrap, channels
// (R13) Vector 4: wake interval elapsed
// (R14) Vector 3: undervolt, gated by enable
// (R15) Vector 1: software interrupt, no gating
// (R16) Vector 0 for every reset source
// (R17) Detector runs only when enabled
// (R18) Stop disables detector unless stop-enabled
// (R19) Stop with both bits enters stop4
// (R20) Power-on holds reset until above low
// (R21) Undervolt reset held until above level
// (R22) Undervolt without reset sets flag, interrupts
// (R23) Vectors 9 and 2 never requested
`timescale 1ns/1ps
`default_nettype none
`include "ivlr_params.svh"
module ivlr_top (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_we,
    input wire logic reg_re,
    output logic [7:0] reg_rdata,
    // Peripheral and reset sources
    input wire ivlr_pkg::ivlr_src_s src,
    input wire ivlr_pkg::ivlr_rsrc_s rsrc,
    // Supply comparators
    input wire logic supply_below_sel,
    input wire logic supply_below_low,
    // Core side
    input wire logic swi_exec,
    input wire logic vec_fetch,
    input wire logic stop_req,
    input wire logic wait_req,
    output ivlr_pkg::ivlr_vec_s vec,
    output logic core_reset,
    output logic [1:0] power_mode,
    output logic lvd_active,
    output logic [7:0] ifp
);
    ////////////////////////////////////////////////////////////////////////
    // State
    logic [7:0] ifp_q; // Shared flag parameter byte
    logic [7:0] ena_q; // Enables, vectors 15..8
    logic [3:0] enb_q; // Enables, vectors 7,6,5,3
    logic [5:0] pwr_q; // Detector control, undervolt flag and temp restart enable
    logic [7:0] rst_stat_q; // Cause of the last reset
    logic swi_q; // Pending software interrupt
    logic [3:0] cnt_q; // Reset hold counter
    logic [7:0] rdata_q;
    logic core_reset_q;
    logic lvd_active_q;
    ivlr_pkg::ivlr_vec_s vec_q;
    ivlr_pkg::ivlr_mode_e mode_q;
    ivlr_pkg::ivlr_rs_e rs_q;
    logic [15:0] raw; // Ungated conditions per vector
    logic [15:0] req; // Gated requests per vector
    logic [7:0] grp_raw; // Conditions folded into flag byte bits
    logic [3:0] win;
    ivlr_pkg::ivlr_vec_s vec_d;
    logic lvd_rst_cond;
    logic other_rst;
    logic [7:0] other_cause;
    logic wr_pwr;

    ////////////////////////////////////////////////////////////////////////
    // Source gating
    always_comb begin
        raw = 16'h0000;
        req = 16'h0000;
        raw[15] = src.keypin_flag; // [R7]
        req[15] = raw[15] & ena_q[0]; // [R4]
        raw[14] = src.press_done_flag;
        req[14] = raw[14] & ena_q[1]; // [R7]
        raw[13] = src.accel_done_flag;
        req[13] = raw[13] & ena_q[2]; // [R7]
        raw[12] = src.periodic_tick_flag;
        req[12] = raw[12] & ena_q[3]; // [R8]
        // One enable covers both receiver flags
        raw[11] = src.carrier_seen_flag | src.byte_decoded_flag;
        req[11] = raw[11] & ena_q[4]; // [R9]
        raw[10] = src.conversion_done_flag;
        req[10] = raw[10] & ena_q[5]; // [R10]
        // Transmit empty has its own enable apart from receive and fault
        raw[8] = src.serial_rx_full_flag | src.serial_fault_flag | src.serial_tx_empty_flag;
        req[8] = ((src.serial_rx_full_flag | src.serial_fault_flag) & ena_q[6])
            | (src.serial_tx_empty_flag & ena_q[7]); // [R11]
        raw[7] = src.counter_wrap_flag;
        req[7] = raw[7] & enb_q[0]; // [R12]
        raw[6] = src.chan_b_flag;
        req[6] = raw[6] & enb_q[1]; // [R12]
        raw[5] = src.chan_a_flag;
        req[5] = raw[5] & enb_q[2]; // [R12]
        // Wake interval carries its gating inside the wake unit
        raw[4] = src.wake_interval_flag;
        req[4] = raw[4]; // [R13]
        raw[3] = pwr_q[`IVLR_PWR_FLAG];
        req[3] = raw[3] & enb_q[3]; // [R14]
        raw[1] = swi_q;
        req[1] = swi_q; // [R15]
        // Slots 9, 2 and 0 stay zero from the defaults above [R23]
    end

    ////////////////////////////////////////////////////////////////////////
    // Priority pick: lowest number is highest address, so it wins
    always_comb begin
        win = 4'h0;
        for (int i = 15; i >= 1; i--) begin
            if (req[i]) begin
                win = 4'(i); // [R1]
            end
        end
    end

    // Vector words; reset and idle point at vector 0
    always_comb begin
        vec_d.req = |req;
        vec_d.num = core_reset_q ? 4'h0 : win; // [R16]
        vec_d.user_addr = `IVLR_USER_BASE + {11'h000, ~vec_d.num, 1'b0}; // [R1]
        vec_d.hw_addr = `IVLR_HW_BASE | {10'h000, vec_d.user_addr[5:0]}; // [R2]
        if (core_reset_q) begin
            vec_d.req = 1'b0;
        end
    end

    // Registered vector toward the core
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Idle words point at vector 0, so the table is never left after reset
            vec_q <= {1'b0, 4'h0, `IVLR_VEC_RST_USER, `IVLR_VEC_RST_HW};
        end else begin
            vec_q <= vec_d; // [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Shared flag byte, one bit per vector group
    assign grp_raw = {raw[4] | raw[3], |raw[8:5], raw[10], raw[11],
        raw[12], raw[13], raw[14], raw[15]};

    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_ifp
            // A set in the same cycle as a write wins over the write
            always_ff @(posedge sys_clk or negedge rst_n) begin
                if (!rst_n) begin
                    ifp_q[g] <= 1'b0;
                end else if (core_reset_q) begin
                    ifp_q[g] <= 1'b0;
                end else if (grp_raw[g]) begin
                    ifp_q[g] <= 1'b1; // [R3]
                end else if (reg_we && reg_addr == `IVLR_A_IFP) begin
                    ifp_q[g] <= reg_wdata[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Local enables, cleared by any system reset
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ena_q <= 8'h00;
            enb_q <= 4'h0;
        end else if (core_reset_q) begin
            ena_q <= 8'h00;
            enb_q <= 4'h0;
        end else if (reg_we && reg_addr == `IVLR_A_ENA) begin
            ena_q <= reg_wdata;
        end else if (reg_we && reg_addr == `IVLR_A_ENB) begin
            enb_q <= reg_wdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Detector control; only power-on clears it so it survives its own reset; the flag also clears on any core reset
    assign wr_pwr = reg_we && reg_addr == `IVLR_A_PWR;

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwr_q <= `IVLR_PWR_RV;
        end else begin
            if (wr_pwr) begin
                pwr_q[3:0] <= reg_wdata[3:0];
                pwr_q[`IVLR_PWR_TRE] <= reg_wdata[`IVLR_PWR_TRE];
            end
            // Flag: set on undervolt in interrupt configuration, write one clears
            if (lvd_active_q && !pwr_q[`IVLR_PWR_RSTE] && supply_below_sel) begin
                pwr_q[`IVLR_PWR_FLAG] <= 1'b1; // [R22]
            end else if (core_reset_q) begin
                pwr_q[`IVLR_PWR_FLAG] <= 1'b0;
            end else if (wr_pwr && reg_wdata[`IVLR_PWR_FLAG]) begin
                pwr_q[`IVLR_PWR_FLAG] <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Software interrupt latch, dropped when the core fetches vector 1
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            swi_q <= 1'b0;
        end else if (swi_exec) begin
            swi_q <= 1'b1; // [R15]
        end else if (core_reset_q || (vec_fetch && vec_q.num == 4'h1)) begin
            swi_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Power mode
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            mode_q <= ivlr_pkg::MD_RUN;
        end else if (core_reset_q) begin
            mode_q <= ivlr_pkg::MD_RUN;
        end else begin
            case (mode_q)
                ivlr_pkg::MD_RUN: begin
                    if (stop_req) begin
                        // Detector kept alive in stop forces the shallow stop
                        if (pwr_q[`IVLR_PWR_STP] && pwr_q[`IVLR_PWR_DET]) begin
                            mode_q <= ivlr_pkg::MD_STOP4; // [R19]
                        end else begin
                            mode_q <= ivlr_pkg::MD_STOP_DEEP;
                        end
                    end else if (wait_req) begin
                        mode_q <= ivlr_pkg::MD_WAIT;
                    end
                end
                default: begin
                    // Any pending vector or fetch brings the part back
                    if (vec_fetch || (|req)) begin
                        mode_q <= ivlr_pkg::MD_RUN; // [R6]
                    end
                end
            endcase
        end
    end

    // Detector on only when enabled and, in stop, only if stop-enabled
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvd_active_q <= 1'b0;
        end else begin
            lvd_active_q <= pwr_q[`IVLR_PWR_DET] // [R17]
                && (mode_q == ivlr_pkg::MD_RUN || mode_q == ivlr_pkg::MD_WAIT
                || pwr_q[`IVLR_PWR_STP]); // [R18]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Reset sequencing
    assign lvd_rst_cond = lvd_active_q && pwr_q[`IVLR_PWR_RSTE] && supply_below_sel;
    assign other_cause = {1'b0, rsrc.illegal_address, rsrc.illegal_opcode,
        rsrc.temp_restart && pwr_q[`IVLR_PWR_TRE], rsrc.watchdog_timeout,
        rsrc.periodic_reset_flag, 2'b00};
    assign other_rst = |other_cause;

    // Power-on starts in the hold state with both voltage causes shown
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rs_q <= ivlr_pkg::RS_HOLD_LV;
            core_reset_q <= 1'b1;
            rst_stat_q <= `IVLR_RST_STAT_RV; // [R20]
            cnt_q <= 4'h0;
        end else begin
            case (rs_q)
                ivlr_pkg::RS_RUN: begin
                    if (lvd_rst_cond) begin
                        rs_q <= ivlr_pkg::RS_HOLD_LV;
                        core_reset_q <= 1'b1; // [R21]
                        rst_stat_q <= 8'h01 << `IVLR_RS_LVD; // [R21]
                    end else if (other_rst) begin
                        rs_q <= ivlr_pkg::RS_HOLD_CNT;
                        core_reset_q <= 1'b1; // [R16]
                        rst_stat_q <= other_cause;
                        cnt_q <= `IVLR_HOLD_CYC;
                    end
                end
                ivlr_pkg::RS_HOLD_LV: begin
                    // Power-on waits for the low level, undervolt for the chosen one
                    if (rst_stat_q[`IVLR_RS_POR] ? !supply_below_low // [R20]
                        : !supply_below_sel) begin // [R21]
                        rs_q <= ivlr_pkg::RS_RUN;
                        core_reset_q <= 1'b0;
                    end
                end
                ivlr_pkg::RS_HOLD_CNT: begin
                    if (cnt_q <= 4'h1) begin
                        rs_q <= ivlr_pkg::RS_RUN;
                        core_reset_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q - 4'h1;
                    end
                end
                default: begin
                    rs_q <= ivlr_pkg::RS_HOLD_LV;
                    core_reset_q <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read, data one cycle after the strobe
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 8'h00;
        end else if (reg_re) begin
            case (reg_addr)
                `IVLR_A_IFP: rdata_q <= ifp_q;
                `IVLR_A_ENA: rdata_q <= ena_q;
                `IVLR_A_ENB: rdata_q <= {4'h0, enb_q};
                `IVLR_A_PWR: rdata_q <= {2'b00, pwr_q};
                `IVLR_A_RST: rdata_q <= rst_stat_q;
                `IVLR_A_VEC: rdata_q <= {vec_q.req, 3'b000, vec_q.num};
                `IVLR_A_MODE: rdata_q <= {5'h00, lvd_active_q, mode_q};
                default: rdata_q <= 8'h00; // Unmapped reads as zero
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign ifp = ifp_q;
    assign vec = vec_q;
    assign core_reset = core_reset_q;
    assign power_mode = mode_q;
    assign lvd_active = lvd_active_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    a_gate_no_req: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R4]
        !(|req) |=> !vec_q.req)
        else $error("request without gated source");
    a_vec_priority: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R1]
        (req[3] && !core_reset_q) |=> (vec_q.num <= 4'h3 && vec_q.num != 4'h0))
        else $error("lower priority vector chosen");
    a_hw_table: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R2]
        vec_q.hw_addr[15:6] == 10'h3FF && vec_q.hw_addr[0] == 1'b0
        && vec_q.hw_addr[5:0] == vec_q.user_addr[5:0])
        else $error("hardware vector outside table");
    a_reserved_idle: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R23]
        vec_q.req |-> (vec_q.num != 4'h9 && vec_q.num != 4'h2))
        else $error("reserved vector requested");
    a_flag_byte_set: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R3]
        (src.keypin_flag && !core_reset_q) |=> ifp_q[0])
        else $error("flag byte bit not set");
    a_swi_request: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R15]
        (swi_exec && !core_reset_q) ##1 !core_reset_q |=> vec_q.req)
        else $error("software interrupt not requested");
    a_wake_run: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R6]
        (mode_q != ivlr_pkg::MD_RUN && vec_fetch) |=> mode_q == ivlr_pkg::MD_RUN)
        else $error("no wake on vector fetch");
    a_stop4_entry: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R19]
        (mode_q == ivlr_pkg::MD_RUN && stop_req && !core_reset_q
        && pwr_q[`IVLR_PWR_STP] && pwr_q[`IVLR_PWR_DET])
        |=> mode_q == ivlr_pkg::MD_STOP4)
        else $error("stop4 not entered");
    a_deep_stop_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R18]
        (mode_q == ivlr_pkg::MD_STOP_DEEP && $stable(mode_q)) |-> !lvd_active_q)
        else $error("detector alive in deep stop");
    a_lvd_reset_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R21]
        (lvd_rst_cond && rs_q == ivlr_pkg::RS_RUN)
        |=> core_reset_q && rst_stat_q[`IVLR_RS_LVD] ##1 !vec_q.req && vec_q.num == 4'h0
        && (core_reset_q || !$past(supply_below_sel)))
        else $error("undervolt reset not held");
    a_por_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // [R20]
        (rs_q == ivlr_pkg::RS_HOLD_LV && rst_stat_q[`IVLR_RS_POR] && supply_below_low)
        |=> core_reset_q)
        else $error("power-on hold released early");
endmodule
`default_nettype wire

//--- testbench/ivlr_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// Core stand-in: takes a pending vector after a short or long delay, then stays masked for a fixed time
module ivlr_core_model (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Vector side
    input wire ivlr_pkg::ivlr_vec_s vec,
    input wire logic slow,
    output logic vec_fetch
);
    logic [3:0] cnt_q; // Cycles spent finishing an instruction or in a handler
    logic mask_q; // Global mask, set out of reset
    ////////////////////////////////////////////////////////////////////////
    // Finish instruction, stack, set mask, fetch; a short handler then unmasks
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= 4'h0;
            mask_q <= 1'b1;
            vec_fetch <= 1'b0;
        end else begin
            vec_fetch <= 1'b0;
            if (mask_q) begin
                // Handler runs a fixed time, then the stacked mask comes back clear
                cnt_q <= (cnt_q == 4'h7) ? 4'h0 : cnt_q + 4'h1;
                mask_q <= (cnt_q != 4'h7);
            end else if (vec.req) begin
                // Slow mode stands for a long instruction still in flight
                cnt_q <= cnt_q + 4'h1;
                if (cnt_q == (slow ? 4'h6 : 4'h1)) begin
                    vec_fetch <= 1'b1;
                    mask_q <= 1'b1;
                    cnt_q <= 4'h0;
                end
            end else begin
                cnt_q <= 4'h0;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/ivlr_top_bench.sv
`timescale 1ns/1ps
`default_nettype none
module ivlr_top_bench;
    logic sys_clk, rst_n, reg_we, reg_re, below_sel, below_low, swi_exec, stop_req, wait_req;
    logic slow, vec_fetch, core_reset, lvd_active;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, ifp, d;
    logic [1:0] power_mode;
    ivlr_pkg::ivlr_src_s src;
    ivlr_pkg::ivlr_rsrc_s rsrc;
    ivlr_pkg::ivlr_vec_s vec;
    int n_errors, comparisons, cycles;
    logic [31:0] seed;
    // Vector number of each source bit, wake interval at bit 0
    logic [3:0] vn [0:13] = '{4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h8, 4'h8, 4'hA,
                              4'hB, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF};
    ////////////////////////////////////////////////////////////////////////
    ivlr_top u_ivlr_top (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re), .reg_rdata(reg_rdata),
        .src(src), .rsrc(rsrc), .supply_below_sel(below_sel), .supply_below_low(below_low),
        .swi_exec(swi_exec), .vec_fetch(vec_fetch), .stop_req(stop_req), .wait_req(wait_req),
        .vec(vec), .core_reset(core_reset), .power_mode(power_mode),
        .lvd_active(lvd_active), .ifp(ifp));
    ivlr_core_model u_ivlr_core_model (.sys_clk(sys_clk), .rst_n(rst_n), .vec(vec),
        .slow(slow), .vec_fetch(vec_fetch));
    ////////////////////////////////////////////////////////////////////////
    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // Hang guard, well above the length of the sequence
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            complete_run();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    // Lowest vector number wins, as it sits at the highest address
    function automatic logic [3:0] exp_num(input logic [13:0] s);
        logic [3:0] b;
        b = 4'h0;
        for (int i = 0; i < 14; i++) if (s[i] && (b == 4'h0 || vn[i] < b)) b = vn[i];
        return b;
    endfunction
    function automatic logic [15:0] uaddr(input logic [3:0] n);
        return 16'hDFE0 + {11'h000, 4'hF - n, 1'b0};
    endfunction
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        reg_we <= 1'b1;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge sys_clk);
        reg_we <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        reg_re <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_re <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // One-cycle strobe: 0 swi, 1 stop, 2 wait, 3..7 reset source bits 0..4
    task automatic pulse(input int w);
        @(posedge sys_clk);
        {rsrc, wait_req, stop_req, swi_exec} <= 8'h01 << w;
        @(posedge sys_clk);
        {rsrc, wait_req, stop_req, swi_exec} <= 8'h00;
    endtask
    // Bounded wait for the core reset to let go
    task automatic wait_rel();
        int k;
        k = 0;
        while (core_reset !== 1'b0 && k < 60) begin
            cyc(1);
            k++;
        end
        chk("core_reset_release", {15'h0, core_reset}, 16'h0);
    endtask
    task automatic complete_run();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {rst_n, reg_we, reg_re, below_sel, swi_exec, stop_req, wait_req, slow} = '0;
        {reg_addr, reg_wdata, src, rsrc} = '0;
        below_low = 1'b1;
        seed = 32'hBB9F7296;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        // Supply still under the low level keeps the core in reset
        cyc(6);
        chk("por_hold", {15'h0, core_reset}, 16'h1);
        @(posedge sys_clk) below_low <= 1'b0;
        wait_rel();
        rd(8'h63, d);
        chk("status_por", {8'h0, d}, 16'h0003);
        rd(8'h62, d);
        chk("power_reset", {8'h0, d}, 16'h0009);
        rd(8'h70, d);
        chk("unmapped", {8'h0, d}, 16'h0000);
        // Flags with no enables: parameter byte sets, no request
        @(posedge sys_clk) src <= ivlr_pkg::ivlr_src_s'(14'h3FFE);
        cyc(3);
        chk("gated_req", {15'h0, vec.req}, 16'h0);
        rd(8'h5F, d);
        chk("param_byte", {8'h0, d}, 16'h007F);
        chk("ifp_port", {8'h0, ifp}, 16'h007F);
        wr(8'h60, 8'hFF);
        wr(8'h61, 8'h0F);
        // Every source alone: number, user and hardware address
        for (int i = 0; i < 14; i++) begin
            @(posedge sys_clk) src <= ivlr_pkg::ivlr_src_s'(14'h1 << i);
            cyc(2);
            chk("vec_num", {12'h0, vec.num}, {12'h0, vn[i]});
            chk("user_addr", vec.user_addr, uaddr(vn[i]));
            chk("hw_addr", vec.hw_addr, 16'hFFC0 | uaddr(vn[i]));
        end
        // Random mixes of pending sources
        for (int k = 0; k < 24; k++) begin
            seed = xs(seed);
            @(posedge sys_clk) src <= ivlr_pkg::ivlr_src_s'(seed[13:0]);
            cyc(2);
            chk("prio_num", {12'h0, vec.num}, {12'h0, exp_num(seed[13:0])});
        end
        // Software interrupt held until the slow core fetches it
        @(posedge sys_clk) src <= '0;
        slow <= 1'b1;
        cyc(12);
        pulse(0);
        cyc(1);
        chk("swi_num", {12'h0, vec.num}, 16'h0001);
        chk("swi_addr", vec.user_addr, 16'hDFFC);
        for (int k = 0; k < 30 && vec.req === 1'b1; k++) cyc(1);
        chk("swi_taken", {15'h0, vec.req}, 16'h0);
        // Undervolt as an interrupt, reset off
        wr(8'h62, 8'h01);
        @(posedge sys_clk) below_sel <= 1'b1;
        cyc(3);
        chk("uv_num", {12'h0, vec.num}, 16'h0003);
        chk("uv_noreset", {15'h0, core_reset}, 16'h0);
        rd(8'h62, d);
        chk("uv_flag", {15'h0, d[4]}, 16'h1);
        @(posedge sys_clk) below_sel <= 1'b0;
        wr(8'h62, 8'h11);
        cyc(2);
        chk("uv_clear", {15'h0, vec.req}, 16'h0);
        // Detector off: no activity, low supply ignored
        wr(8'h62, 8'h00);
        @(posedge sys_clk) below_sel <= 1'b1;
        cyc(3);
        chk("det_off", {14'h0, lvd_active, vec.req}, 16'h0);
        @(posedge sys_clk) below_sel <= 1'b0;
        // Stop with detector kept, then deep stop, then wait
        for (int m = 0; m < 3; m++) begin
            wr(8'h62, m == 0 ? 8'h05 : 8'h01);
            cyc(12);
            if (m < 2) pulse(1);
            else pulse(2);
            cyc(2);
            chk("mode", {14'h0, power_mode}, m == 0 ? 16'h2 : (m == 1 ? 16'h3 : 16'h1));
            chk("det_stop", {15'h0, lvd_active}, m == 1 ? 16'h0 : 16'h1);
            if (m < 2) @(posedge sys_clk) src <= ivlr_pkg::ivlr_src_s'(14'h0001);
            else pulse(0);
            cyc(3);
            chk("wake", {14'h0, power_mode}, 16'h0);
            @(posedge sys_clk) src <= '0;
        end
        cyc(20);
        // Each non-voltage reset source
        for (int i = 0; i < 5; i++) begin
            wr(8'h62, 8'h29);
            pulse(3 + i);
            cyc(1);
            chk("rst_on", {14'h0, core_reset, vec.req}, 16'h2);
            wait_rel();
            rd(8'h63, d);
            chk("rst_cause", {8'h0, d}, 16'h1 << (6 - i));
        end
        // Undervolt reset held while the supply stays low
        @(posedge sys_clk) below_sel <= 1'b1;
        cyc(10);
        chk("uv_hold", {15'h0, core_reset}, 16'h1);
        @(posedge sys_clk) below_sel <= 1'b0;
        wait_rel();
        rd(8'h63, d);
        chk("uv_cause", {8'h0, d}, 16'h0002);
        complete_run();
    end
endmodule
`default_nettype wire
